/* addr_ptr_pkg.sv */
package addr_ptr_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [15:0] PAGE_ZERO_OFS = 16'hfe00;
    localparam logic [15:0] PAGE_ONE_OFS = 16'hfe02;
    localparam logic [15:0] PAGE_TWO_OFS = 16'hfe04;
    localparam logic [15:0] PAGE_THREE_OFS = 16'hfe06;
    localparam logic [15:0] BANK_BASE_OFS = 16'hfe10;

    // ****************************************
    // field layouts
    // ****************************************
    localparam int PAGE_NUM_W = 4;
    localparam int SEG_NUM_W = 2;
    localparam int PAGE_OFS_W = 14;
    localparam int PHYS_W = 18;
    localparam int HOLD_EN_BIT = 10;
    localparam int BANK_FREE_LSB = 1;
    localparam int BANK_FREE_MSB = 9;
    localparam int BANK_INV_BIT = 10;
    localparam logic [4:0] BANK_TIED_HIGH = 5'h1f;
    localparam logic [2:0] FETCH_STEP_DEFAULT = 3'h2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0] PAGE_ZERO_RST = 4'h0;
    localparam logic [3:0] PAGE_ONE_RST = 4'h1;
    localparam logic [3:0] PAGE_TWO_RST = 4'h2;
    localparam logic [3:0] PAGE_THREE_RST = 4'h3;
    localparam logic [15:0] BANK_BASE_RST = 16'hfc00;
    localparam logic [1:0] SEG_RST = 2'h0;
    localparam logic [15:0] OFFSET_RST = 16'h0000;

    // ****************************************
    // arbitration pin function
    // ****************************************
    typedef enum logic [2:0] {
        PINS_GENERAL = 3'b001,
        PINS_ARB_ON = 3'b010,
        PINS_ARB_OFF = 3'b100
    } pin_mode_e;
endpackage

/* addr_ext_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface addr_ext_if;
    logic [15:0] offset;
    logic [3:0] bank;
    logic segmented;
    logic bypass;
    logic [17:0] phys;

    modport requester (
        output offset,
        output bank,
        output segmented,
        output bypass,
        input phys
    );
    modport extender (
        input offset,
        input bank,
        input segmented,
        input bypass,
        output phys
    );
endinterface
`default_nettype wire

/* page_extend.sv */
`timescale 1ns/100ps
`default_nettype none
module page_extend #(
    parameter int OFS_W = 14
) (
    // request and result
    addr_ext_if.extender ext
);
    // ****************************************
    // page number over page offset
    // ****************************************
    always_comb begin
        if (ext.bypass) begin
            ext.phys = {2'b00, ext.offset};
        end else if (ext.segmented) begin
            ext.phys = {ext.bank, ext.offset[OFS_W-1:0]};
        end else begin
            ext.phys = {2'b00, ext.bank[1:0], ext.offset[OFS_W-1:0]};
        end
    end
endmodule
`default_nettype wire

/* code_extend.sv */
`timescale 1ns/100ps
`default_nettype none
module code_extend (
    // request and result
    addr_ext_if.extender ext
);
    // ****************************************
    // segment number over offset
    // ****************************************
    always_comb begin
        if (ext.segmented && !ext.bypass) begin
            ext.phys = {ext.bank[1:0], ext.offset};
        end else begin
            ext.phys = {2'b00, ext.offset};
        end
    end
endmodule
`default_nettype wire

/* cpu_address_pointer_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_address_pointer_regs #(
    parameter int PAGES = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // special function register access
    input wire logic [15:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [15:0] sfrWrData,
    input wire logic sfrRdEn,
    output logic [15:0] sfrRdData,
    output logic sfrRdHit,
    // mode and status
    input wire logic [15:0] processorStatusWord,
    input wire logic segmentedMode,
    // instruction pipeline events
    input wire logic instrBoundary,
    input wire logic fetchAdvance,
    input wire logic [2:0] fetchLength,
    input wire logic branchTaken,
    input wire logic [15:0] branchTarget,
    input wire logic returnOp,
    input wire logic farJumpOp,
    input wire logic farCallOp,
    input wire logic [1:0] farTargetSeg,
    input wire logic [15:0] farTargetOffset,
    input wire logic farReturnOp,
    input wire logic interruptReturnOp,
    input wire logic [1:0] stackSeg,
    input wire logic [15:0] stackOffset,
    input wire logic interruptAccept,
    input wire logic trapExec,
    input wire logic [15:0] vectorOffset,
    input wire logic switchContextOp,
    input wire logic [15:0] newContext,
    // pointer state
    output logic [15:0] instructionPointer,
    output logic [1:0] codeSegmentSelect,
    output logic [15:0] gprBankBase,
    output logic [15:0] pushedContext,
    output logic pushedContextValid,
    // code fetch address
    input wire logic codeFetchReq,
    input wire logic codeFetchExternal,
    output logic [17:0] codePhysAddr,
    output logic codeAddrValid,
    // data access address
    input wire logic dataReq,
    input wire logic [15:0] dataAddr,
    input wire logic dataPecXfer,
    input wire logic dataExternal,
    output logic [17:0] dataPhysAddr,
    output logic dataAddrValid,
    // upper address lines
    output logic [1:0] segAddrLines,
    output logic segAddrLinesOe,
    // bus arbitration pins
    input wire logic holdReqPin,
    input wire logic ackFromBus,
    input wire logic busReqFromBus,
    output logic holdReqToBus,
    output logic holdAckPinOut,
    output logic holdAckPinOe,
    output logic busReqPinOut,
    output logic busReqPinOe,
    output logic port2AltSelect
);
    // ****************************************
    // storage
    // ****************************************
    localparam int BANK_W =
        addr_ptr_pkg::BANK_FREE_MSB - addr_ptr_pkg::BANK_FREE_LSB + 1;
    localparam logic [3:0] PAGE_RST [4] = '{addr_ptr_pkg::PAGE_ZERO_RST,
        addr_ptr_pkg::PAGE_ONE_RST, addr_ptr_pkg::PAGE_TWO_RST,
        addr_ptr_pkg::PAGE_THREE_RST};
    logic [3:0] pageReg [PAGES];
    logic [3:0] pageStage_reg [PAGES], pageEff_reg [PAGES];
    logic [BANK_W-1:0] bankFree_reg;
    logic [15:0] bankStage_reg;
    logic [1:0] seg_reg;
    logic [15:0] offset_reg;
    addr_ptr_pkg::pin_mode_e pinMode_reg, pinMode_next;
    logic holdEnable;
    logic [15:0] bankFull, newBankFull;
    logic [1:0] pageIdx;
    addr_ext_if codeExt ();
    addr_ext_if dataExt ();

    // ****************************************
    // bank base with tied bits
    // ****************************************
    function automatic logic [15:0] bankCompose(
        input logic [BANK_W-1:0] free
    );
        bankCompose = {addr_ptr_pkg::BANK_TIED_HIGH, ~free[BANK_W-1],
            free, 1'b0};
    endfunction
    assign bankFull = bankCompose(bankFree_reg);
    assign newBankFull = bankCompose(
        newContext[addr_ptr_pkg::BANK_FREE_MSB:addr_ptr_pkg::BANK_FREE_LSB]);
    assign holdEnable =
        processorStatusWord[addr_ptr_pkg::HOLD_EN_BIT];
    assign pageIdx = dataAddr[15:14];
    // ****************************************
    // page registers
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pageReg <= PAGE_RST;
        end else if (sfrWrEn) begin
            case (sfrAddr)
                addr_ptr_pkg::PAGE_ZERO_OFS, addr_ptr_pkg::PAGE_ONE_OFS,
                addr_ptr_pkg::PAGE_TWO_OFS, addr_ptr_pkg::PAGE_THREE_OFS: begin
                    pageReg[sfrAddr[2:1]] <= sfrWrData[3:0];
                end
                default: begin
                end
            endcase
        end
    end
    // ****************************************
    // page values seen by address calculation
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pageStage_reg <= PAGE_RST;
            pageEff_reg <= PAGE_RST;
        end else if (instrBoundary) begin
            for (int i = 0; i < PAGES; i++) begin
                pageStage_reg[i] <= pageReg[i];
                pageEff_reg[i] <= pageStage_reg[i];
            end
        end
    end
    // ****************************************
    // register bank base
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bankFree_reg <= addr_ptr_pkg::BANK_BASE_RST[
                addr_ptr_pkg::BANK_FREE_MSB:addr_ptr_pkg::BANK_FREE_LSB];
        end else if (switchContextOp) begin
            bankFree_reg <= newContext[
                addr_ptr_pkg::BANK_FREE_MSB:addr_ptr_pkg::BANK_FREE_LSB];
        end else if (sfrWrEn && sfrAddr == addr_ptr_pkg::BANK_BASE_OFS) begin
            bankFree_reg <= sfrWrData[
                addr_ptr_pkg::BANK_FREE_MSB:addr_ptr_pkg::BANK_FREE_LSB];
        end
    end
    // one cycle push and load
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pushedContext <= addr_ptr_pkg::BANK_BASE_RST;
            pushedContextValid <= 1'b0;
        end else begin
            pushedContextValid <= switchContextOp;
            if (switchContextOp) begin
                pushedContext <= bankFull;
            end
        end
    end
    // bank base seen by register address calculation
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bankStage_reg <= addr_ptr_pkg::BANK_BASE_RST;
            gprBankBase <= addr_ptr_pkg::BANK_BASE_RST;
        end else if (instrBoundary) begin
            bankStage_reg <= bankFull;
            gprBankBase <= bankStage_reg;
        end
    end
    // ****************************************
    // code segment
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seg_reg <= addr_ptr_pkg::SEG_RST;
        end else if (interruptAccept || trapExec) begin
            seg_reg <= addr_ptr_pkg::SEG_RST;
        end else if (farJumpOp || farCallOp) begin
            seg_reg <= farTargetSeg;
        end else if (farReturnOp || interruptReturnOp) begin
            seg_reg <= stackSeg;
        end
    end

    // ****************************************
    // instruction pointer
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            offset_reg <= addr_ptr_pkg::OFFSET_RST;
        end else if (interruptAccept || trapExec) begin
            offset_reg <= vectorOffset;
        end else if (farJumpOp || farCallOp) begin
            offset_reg <= farTargetOffset;
        end else if (returnOp || farReturnOp || interruptReturnOp) begin
            offset_reg <= stackOffset;
        end else if (branchTaken) begin
            offset_reg <= branchTarget;
        end else if (fetchAdvance) begin
            offset_reg <= offset_reg + {13'h0000, fetchLength};
        end
    end
    assign instructionPointer = offset_reg;
    assign codeSegmentSelect = seg_reg;
    // ****************************************
    // address extension
    // ****************************************
    assign codeExt.offset = offset_reg;
    assign codeExt.bank = {2'b00, seg_reg};
    assign codeExt.segmented = segmentedMode;
    assign codeExt.bypass = 1'b0;
    assign dataExt.offset = dataAddr;
    assign dataExt.bank = pageEff_reg[pageIdx];
    assign dataExt.segmented = segmentedMode;
    assign dataExt.bypass = dataPecXfer;
    code_extend codeExtender (
        .ext(codeExt.extender)
    );
    page_extend #(
        .OFS_W(addr_ptr_pkg::PAGE_OFS_W)
    ) dataExtender (
        .ext(dataExt.extender)
    );

    // ****************************************
    // registered addresses and upper lines
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            codePhysAddr <= 18'h0_0000;
            codeAddrValid <= 1'b0;
            dataPhysAddr <= 18'h0_0000;
            dataAddrValid <= 1'b0;
        end else begin
            codeAddrValid <= codeFetchReq;
            dataAddrValid <= dataReq;
            if (codeFetchReq) begin
                codePhysAddr <= codeExt.phys;
            end
            if (dataReq) begin
                dataPhysAddr <= dataExt.phys;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            segAddrLines <= 2'h0;
            segAddrLinesOe <= 1'b0;
        end else if (segmentedMode && codeFetchReq && codeFetchExternal) begin
            segAddrLines <= seg_reg;
            segAddrLinesOe <= 1'b1;
        end else if (segmentedMode && dataReq && dataExternal) begin
            segAddrLines <= dataExt.phys[17:16];
            segAddrLinesOe <= 1'b1;
        end else begin
            segAddrLines <= 2'h0;
            segAddrLinesOe <= 1'b0;
        end
    end

    // ****************************************
    // arbitration pin function
    // ****************************************
    always_comb begin
        case (pinMode_reg)
            addr_ptr_pkg::PINS_GENERAL: begin
                pinMode_next = holdEnable ? addr_ptr_pkg::PINS_ARB_ON
                    : addr_ptr_pkg::PINS_GENERAL;
            end
            addr_ptr_pkg::PINS_ARB_ON, addr_ptr_pkg::PINS_ARB_OFF: begin
                pinMode_next = holdEnable ? addr_ptr_pkg::PINS_ARB_ON
                    : addr_ptr_pkg::PINS_ARB_OFF;
            end
            default: begin
                pinMode_next = addr_ptr_pkg::PINS_GENERAL;
            end
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinMode_reg <= addr_ptr_pkg::PINS_GENERAL;
        end else begin
            pinMode_reg <= pinMode_next;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port2AltSelect <= 1'b0;
            holdReqToBus <= 1'b0;
            holdAckPinOut <= 1'b1;
            holdAckPinOe <= 1'b0;
            busReqPinOut <= 1'b0;
            busReqPinOe <= 1'b0;
        end else begin
            port2AltSelect <= pinMode_next != addr_ptr_pkg::PINS_GENERAL;
            holdReqToBus <= pinMode_next == addr_ptr_pkg::PINS_ARB_ON
                && !holdReqPin;
            holdAckPinOe <= pinMode_next != addr_ptr_pkg::PINS_GENERAL;
            busReqPinOe <= pinMode_next != addr_ptr_pkg::PINS_GENERAL;
            if (pinMode_next == addr_ptr_pkg::PINS_ARB_ON) begin
                holdAckPinOut <= !ackFromBus;
                busReqPinOut <= !busReqFromBus;
            end else begin
                holdAckPinOut <= 1'b1;
                busReqPinOut <= 1'b1;
            end
        end
    end

    // ****************************************
    // register read
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfrRdData <= 16'h0000;
            sfrRdHit <= 1'b0;
        end else if (sfrRdEn) begin
            sfrRdHit <= 1'b1;
            case (sfrAddr)
                addr_ptr_pkg::PAGE_ZERO_OFS, addr_ptr_pkg::PAGE_ONE_OFS,
                addr_ptr_pkg::PAGE_TWO_OFS, addr_ptr_pkg::PAGE_THREE_OFS: begin
                    sfrRdData <= {12'h000, pageReg[sfrAddr[2:1]]};
                end
                addr_ptr_pkg::BANK_BASE_OFS: begin
                    sfrRdData <= bankFull;
                end
                default: begin
                    sfrRdData <= 16'h0000;
                    sfrRdHit <= 1'b0;
                end
            endcase
        end else begin
            sfrRdData <= 16'h0000;
            sfrRdHit <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* cpu_address_pointer_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_address_pointer_regs_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register access
    input wire logic [15:0] sfrAddr,
    input wire logic sfrRdEn,
    input wire logic [15:0] sfrRdData,
    input wire logic sfrRdHit,
    // mode and events
    input wire logic [15:0] processorStatusWord,
    input wire logic segmentedMode,
    input wire logic farJumpOp,
    input wire logic farCallOp,
    input wire logic [1:0] farTargetSeg,
    input wire logic [15:0] farTargetOffset,
    input wire logic interruptAccept,
    input wire logic trapExec,
    input wire logic [15:0] vectorOffset,
    input wire logic switchContextOp,
    // pointer state
    input wire logic [15:0] instructionPointer,
    input wire logic [1:0] codeSegmentSelect,
    input wire logic [15:0] gprBankBase,
    input wire logic pushedContextValid,
    // addresses
    input wire logic codeFetchReq,
    input wire logic [17:0] codePhysAddr,
    input wire logic dataReq,
    input wire logic dataPecXfer,
    input wire logic [15:0] dataAddr,
    input wire logic [17:0] dataPhysAddr,
    // arbitration
    input wire logic holdReqToBus,
    input wire logic holdAckPinOut,
    input wire logic busReqPinOut,
    input wire logic port2AltSelect
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_unmapped;
        sfrRdEn && !(sfrAddr inside {16'hfe00, 16'hfe02, 16'hfe04, 16'hfe06,
            16'hfe10}) |=> !sfrRdHit && sfrRdData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_page_rsv;
        sfrRdEn && sfrAddr[15:3] == 13'h1fc0 |=> sfrRdData[15:4] == 12'h000;
    endproperty
    a_page_rsv: assert property (p_page_rsv) else $error("page");
    property p_bank_tie;
        !gprBankBase[0] && gprBankBase[15:11] == 5'h1f
            && gprBankBase[10] == !gprBankBase[9];
    endproperty
    a_bank_tie: assert property (p_bank_tie) else $error("bank");
    property p_far;
        (farJumpOp || farCallOp) && !interruptAccept && !trapExec |=>
            codeSegmentSelect == $past(farTargetSeg)
            && instructionPointer == $past(farTargetOffset);
    endproperty
    a_far: assert property (p_far) else $error("far target");
    property p_irq;
        interruptAccept || trapExec |=> codeSegmentSelect == 2'b00
            && instructionPointer == $past(vectorOffset);
    endproperty
    a_irq: assert property (p_irq) else $error("vector entry");
    property p_code;
        codeFetchReq |=> codePhysAddr == {$past(segmentedMode)
            ? $past(codeSegmentSelect) : 2'b00, $past(instructionPointer)};
    endproperty
    a_code: assert property (p_code) else $error("code address");
    property p_pec;
        dataReq && dataPecXfer |=> dataPhysAddr == {2'b00, $past(dataAddr)};
    endproperty
    a_pec: assert property (p_pec) else $error("event address");
    property p_hold;
        processorStatusWord[10] |=> port2AltSelect;
    endproperty
    a_hold: assert property (p_hold) else $error("pins not assigned");
    property p_off;
        !processorStatusWord[10] && port2AltSelect |=> port2AltSelect
            && !holdReqToBus && holdAckPinOut && busReqPinOut;
    endproperty
    a_off: assert property (p_off) else $error("disabled pins");
    property p_ctx;
        switchContextOp |=> pushedContextValid;
    endproperty
    a_ctx: assert property (p_ctx) else $error("context push");
    c_far: cover property (farCallOp);
    c_trap: cover property (trapExec);
    c_off: cover property (port2AltSelect && !processorStatusWord[10]);
endmodule
bind cpu_address_pointer_regs cpu_address_pointer_regs_chk chk (.*);
`default_nettype wire

/* bus_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bus_ctrl_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // hold handshake
    input wire logic holdReqToBus,
    input wire logic wantBus,
    input wire logic slow,
    output logic ackFromBus,
    output logic busReqFromBus
);
    logic [2:0] waitCnt;
    // grant after a short or long wait, drop at once on release
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst || !holdReqToBus) begin
            waitCnt <= 3'h0;
            ackFromBus <= 1'b0;
        end else if (waitCnt == (slow ? 3'h5 : 3'h1)) begin
            ackFromBus <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 3'h1;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) busReqFromBus <= 1'b0;
        else busReqFromBus <= wantBus && !ackFromBus;
    end
endmodule
`default_nettype wire

/* cpu_address_pointer_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_address_pointer_regs_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] sfrAddr, sfrWrData, processorStatusWord, branchTarget;
    logic [15:0] farTargetOffset, stackOffset, vectorOffset, newContext;
    logic [15:0] dataAddr, sfrRdData, instructionPointer, gprBankBase;
    logic [15:0] pushedContext, ip, w;
    logic [2:0] fetchLength;
    logic [1:0] farTargetSeg, stackSeg, codeSegmentSelect, segAddrLines, cs;
    logic [17:0] codePhysAddr, dataPhysAddr;
    logic sfrWrEn, sfrRdEn, segmentedMode, instrBoundary, fetchAdvance;
    logic branchTaken, returnOp, farJumpOp, farCallOp, farReturnOp;
    logic interruptReturnOp, interruptAccept, trapExec, switchContextOp;
    logic codeFetchReq, codeFetchExternal, dataReq, dataPecXfer, rdLag;
    logic dataExternal, holdReqPin, ackFromBus, busReqFromBus, wantBus, slow;
    logic sfrRdHit, pushedContextValid, codeAddrValid, dataAddrValid;
    logic segAddrLinesOe, holdReqToBus, holdAckPinOut, holdAckPinOe;
    logic busReqPinOut, busReqPinOe, port2AltSelect;
    logic [17:0] rdQ[$], codeQ[$], dataQ[$], lineQ[$];
    logic [3:0] pg[4], pgEff[4];
    logic [31:0] r;
    integer seed = 32'h0b95_43eb;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    cpu_address_pointer_regs DUT (.*);
    bus_ctrl_model BCM (.ref_clk(ref_clk), .rst(rst), .slow(slow),
        .holdReqToBus(holdReqToBus), .wantBus(wantBus),
        .ackFromBus(ackFromBus), .busReqFromBus(busReqFromBus));
    always #4 ref_clk = ~ref_clk;
    // ****************************************
    // checking
    // ****************************************
    task check(input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (fail_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        rdLag <= sfrRdEn;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end
    always @(negedge ref_clk) if (!rst) begin
        if (rdLag) check({1'b0, sfrRdHit, sfrRdData}, rdQ.pop_front());
        if (codeAddrValid) check(codePhysAddr, codeQ.pop_front());
        if (dataAddrValid) check(dataPhysAddr, dataQ.pop_front());
        if (segAddrLinesOe) check({16'h0000, segAddrLines}, lineQ.pop_front());
    end
    // ****************************************
    // drivers
    // ****************************************
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1'b1;
        @(negedge ref_clk) s = 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        sfrAddr = a;
        sfrWrData = d;
        pulse(sfrWrEn);
    endtask
    task rd(input logic [15:0] a, input logic [17:0] e);
        sfrAddr = a;
        rdQ.push_back(e);
        pulse(sfrRdEn);
    endtask
    task fetch(input logic seg);
        segmentedMode = seg;
        codeFetchExternal = r[0];
        codeQ.push_back({seg ? cs : 2'b00, ip});
        if (seg && r[0]) lineQ.push_back({16'h0000, cs});
        pulse(codeFetchReq);
    endtask
    task dacc(input logic [15:0] a, input logic seg, input logic pec);
        logic [17:0] e;
        logic [3:0] p;
        p = pgEff[a[15:14]];
        e = pec ? {2'b00, a} : {seg ? p[3:2] : 2'b00, p[1:0], a[13:0]};
        segmentedMode = seg;
        dataAddr = a;
        dataPecXfer = pec;
        dataExternal = !pec;
        dataQ.push_back(e);
        if (seg && !pec) lineQ.push_back({16'h0000, e[17:16]});
        pulse(dataReq);
    endtask
    initial begin
        {sfrAddr, sfrWrData, processorStatusWord, branchTarget} = '0;
        {farTargetOffset, stackOffset, vectorOffset, newContext, dataAddr} = '0;
        {fetchLength, farTargetSeg, stackSeg, sfrWrEn, sfrRdEn, wantBus} = '0;
        {segmentedMode, instrBoundary, fetchAdvance, branchTaken, slow} = '0;
        {farJumpOp, farCallOp, farReturnOp, interruptReturnOp, returnOp} = '0;
        {interruptAccept, trapExec, switchContextOp, codeFetchReq} = '0;
        {codeFetchExternal, dataReq, dataPecXfer, dataExternal} = '0;
        {cs, ip} = '0;
        holdReqPin = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pgEff[i] = 4'(i);
            w = addr_ptr_pkg::PAGE_ZERO_OFS + 16'(2 * i);
            rd(w, 18'(i) | 18'h1_0000);
            r = $random(seed);
            pg[i] = r[3:0];
            wr(w, r[15:0]);
            rd(w, {14'h1000, r[3:0]});
        end
        rd(addr_ptr_pkg::BANK_BASE_OFS, {2'b01, 16'hfc00});
        rd(16'hfe08, 18'h0_0000);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            dacc({2'(i), r[13:0]}, r[14], 1'b0);
        end
        r = $random(seed);
        w = {5'h1f, ~r[9], r[9:1], 1'b0};
        wr(addr_ptr_pkg::BANK_BASE_OFS, r[15:0]);
        rd(addr_ptr_pkg::BANK_BASE_OFS, {2'b01, w});
        check({2'b00, gprBankBase}, {2'b00, 16'hfc00});
        pulse(instrBoundary);
        pulse(instrBoundary);
        pgEff = pg;
        check({2'b00, gprBankBase}, {2'b00, w});
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            dacc(r[15:0], r[16], i > 9);
        end
        newContext = 16'hfc20;
        pulse(switchContextOp);
        check({pushedContextValid, 1'b0, pushedContext}, {2'b10, w});
        rd(addr_ptr_pkg::BANK_BASE_OFS, {2'b01, 16'hfc20});
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            {farTargetSeg, farTargetOffset} = r[17:0];
            {stackSeg, stackOffset} = r[17:0];
            case (k)
                0: pulse(farJumpOp);
                1: pulse(farCallOp);
                2: pulse(farReturnOp);
                default: pulse(interruptReturnOp);
            endcase
            {cs, ip} = r[17:0];
            fetch(1'b1);
            fetch(1'b0);
        end
        fetchLength = r[20:18];
        pulse(fetchAdvance);
        ip = ip + 16'(r[20:18]);
        fetch(1'b1);
        branchTarget = r[31:16];
        pulse(branchTaken);
        ip = r[31:16];
        fetch(1'b1);
        stackOffset = ~r[15:0];
        pulse(returnOp);
        ip = ~r[15:0];
        fetch(1'b0);
        for (int k = 0; k < 2; k++) begin
            farTargetSeg = 2'b11;
            pulse(farJumpOp);
            vectorOffset = 16'(8 * k + 8);
            if (k == 0) pulse(interruptAccept);
            else pulse(trapExec);
            {cs, ip} = {2'b00, vectorOffset};
            fetch(1'b1);
        end
        holdReqPin = 1'b0;
        wantBus = 1'b1;
        slow = r[1];
        processorStatusWord = 16'h0400;
        repeat (10) @(negedge ref_clk);
        check({13'h0000, port2AltSelect, holdAckPinOe, busReqPinOe,
            holdAckPinOut, busReqPinOut}, 18'h0_001d);
        processorStatusWord = 16'h0000;
        repeat (2) @(negedge ref_clk);
        check({15'h0000, port2AltSelect, holdReqToBus, holdAckPinOut},
            18'h0_0005);
        conclude();
    end
endmodule
`default_nettype wire
